// ---- verilog/rtm_retry_timeout_monitor.sv ----
// top of the retry timeout monitor: three target counters and the register file
`timescale 1ns/10ps
`include "rtm_regs.svh"
module rtm_retry_timeout_monitor
  import rtm_pkg::*;
#(
  parameter int CNT_W = `RTM_EXPIRY_LOG2
)
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  // register port
  input  wire logic [`RTM_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // master-side retry events, same clock domain
  input  wire logic                   host_retry,
  input  wire logic                   host_reissue,
  input  wire logic                   card_a_retry,
  input  wire logic                   card_a_reissue,
  input  wire logic                   card_b_retry,
  input  wire logic                   card_b_reissue,
  // status out
  output logic                        host_retry_expired,
  output logic                        card_a_retry_expired,
  output logic                        card_b_retry_expired,
  output logic                        irq
);
  logic host_retry_count_en;
  logic card_retry_count_en;
  logic ev_host, ev_card_a, ev_card_b;
  logic [2:0] exp_r, exp_nxt;

  rtm_retry_counter #(.CNT_W(CNT_W)) u_host
  (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .count_en     (host_retry_count_en),
    .retry_seen   (host_retry),
    .reissue      (host_reissue),
    .expire_pulse (ev_host)
  );

  rtm_retry_counter #(.CNT_W(CNT_W)) u_card_a
  (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .count_en     (card_retry_count_en),
    .retry_seen   (card_a_retry),
    .reissue      (card_a_reissue),
    .expire_pulse (ev_card_a)
  );

  rtm_retry_counter #(.CNT_W(CNT_W)) u_card_b
  (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .count_en     (card_retry_count_en),
    .retry_seen   (card_b_retry),
    .reissue      (card_b_reissue),
    .expire_pulse (ev_card_b)
  );

  rtm_reg_file u_regs
  (
    .core_clk            (core_clk),
    .resetn              (resetn),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .ev_host             (ev_host),
    .ev_card_a           (ev_card_a),
    .ev_card_b           (ev_card_b),
    .host_retry_count_en (host_retry_count_en),
    .card_retry_count_en (card_retry_count_en),
    .irq                 (irq)
  );

  // mirror of the sticky flags for pins; cleared by the same write
  always_comb
  begin
    exp_nxt = exp_r;
    if (reg_wr && reg_addr == `RTM_OFS_STATUS)
      exp_nxt = exp_r & ~{reg_wdata[`RTM_BIT_CARD_B], reg_wdata[`RTM_BIT_CARD_A], reg_wdata[`RTM_BIT_HOST]};
    exp_nxt = exp_nxt | {ev_card_b, ev_card_a, ev_host};
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      exp_r <= 3'h0;
    else
      exp_r <= exp_nxt;
  end

  assign host_retry_expired   = exp_r[0];
  assign card_a_retry_expired = exp_r[1];
  assign card_b_retry_expired = exp_r[2];
endmodule : rtm_retry_timeout_monitor

// ---- common/rtm_regs.svh ----
// register map and timing constants of the retry timeout monitor
// Summary of operation
// - retry not reissued within 2^15 clocks sets that target's expiry flag
// - host-side retry counter runs only while control bit 7 is one; resets to one
// - card-side retry counters run only while control bit 6 is one; resets to one
// - card target B expiry shows in bit 5, reset zero
// - card target A expiry shows in bit 3, reset zero
// - host-side target expiry shows in bit 1, reset zero
// - writing one clears an expiry flag; writing zero leaves it
// - bits 4, 2 and 0 of the status register read zero
// - register sits at offset 0x90, reset value 0xC0; use function 0 only
`ifndef RTM_REGS_SVH
`define RTM_REGS_SVH
`define RTM_ADDR_W         8
`define RTM_OFS_STATUS     8'h90
`define RTM_OFS_IRQ_STAT   8'hA0
`define RTM_OFS_IRQ_MASK   8'hA4
`define RTM_STATUS_RESET   8'hC0
`define RTM_BIT_HOST_EN    7
`define RTM_BIT_CARD_EN    6
`define RTM_BIT_CARD_B     5
`define RTM_BIT_CARD_A     3
`define RTM_BIT_HOST       1
`define RTM_FLAG_MASK      8'h2A
`define RTM_EN_MASK        8'hC0
`define RTM_EXPIRY_LOG2    15
`endif

// ---- common/rtm_pkg.sv ----
// types shared by the retry timeout monitor
package rtm_pkg;
  typedef enum logic [1:0]
  {
    RTM_CNT_IDLE    = 2'b00,
    RTM_CNT_WAITING = 2'b01,
    RTM_CNT_EXPIRED = 2'b10
  } rtm_cnt_state_t;
endpackage : rtm_pkg

// ---- verilog/rtm_retry_counter.sv ----
// one per-target retry timeout counter
`timescale 1ns/10ps
`include "rtm_regs.svh"
module rtm_retry_counter
  import rtm_pkg::*;
#(
  parameter int CNT_W = `RTM_EXPIRY_LOG2
)
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // control
  input  wire logic count_en,
  input  wire logic retry_seen,
  input  wire logic reissue,
  // result
  output logic      expire_pulse
);
  rtm_cnt_state_t   state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  localparam logic [CNT_W-1:0] CNT_LAST = {CNT_W{1'b1}};

  always_comb
  begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    expire_pulse = 1'b0;
    case (state_r)
      RTM_CNT_IDLE:
      begin
        cnt_nxt = '0;
        if (count_en && retry_seen)
          state_nxt = RTM_CNT_WAITING;
      end
      RTM_CNT_WAITING:
      begin
        if (!count_en || reissue)
        begin
          state_nxt = RTM_CNT_IDLE;
          cnt_nxt   = '0;
        end
        else if (cnt_r == CNT_LAST)
        begin
          state_nxt    = RTM_CNT_EXPIRED;
          expire_pulse = 1'b1;
        end
        else
          cnt_nxt = cnt_r + 1'b1;
      end
      RTM_CNT_EXPIRED:
      begin
        // one flag per abandoned request; a new retry rearms at once, a reissue or disable returns to idle
        if (!count_en || reissue || retry_seen)
          state_nxt = retry_seen && count_en ? RTM_CNT_WAITING : RTM_CNT_IDLE;
        cnt_nxt = '0;
      end
      default:
      begin
        state_nxt = RTM_CNT_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_r <= RTM_CNT_IDLE;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end
endmodule : rtm_retry_counter

// ---- verilog/rtm_reg_file.sv ----
// register slave: retry status, interrupt status and mask
`timescale 1ns/10ps
`include "rtm_regs.svh"
module rtm_reg_file
  import rtm_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  // register port
  input  wire logic [`RTM_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // expiry events
  input  wire logic                   ev_host,
  input  wire logic                   ev_card_a,
  input  wire logic                   ev_card_b,
  // control and interrupt
  output logic                        host_retry_count_en,
  output logic                        card_retry_count_en,
  output logic                        irq
);
  logic [7:0] status_r, status_nxt;
  logic [7:0] istat_r, istat_nxt;
  logic [7:0] imask_r, imask_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] ev_vec;

  function automatic logic [7:0] rtm_w1c(input logic [7:0] cur, input logic [7:0] clr,
                                         input logic [7:0] set);
    rtm_w1c = ((cur & ~clr) | set) & `RTM_FLAG_MASK;
  endfunction : rtm_w1c

  always_comb
  begin
    ev_vec = 8'h00;
    ev_vec[`RTM_BIT_HOST]   = ev_host;
    ev_vec[`RTM_BIT_CARD_A] = ev_card_a;
    ev_vec[`RTM_BIT_CARD_B] = ev_card_b;
  end

  always_comb
  begin
    status_nxt = status_r;
    istat_nxt  = rtm_w1c(istat_r, 8'h00, ev_vec);
    imask_nxt  = imask_r;
    rdata_nxt  = 8'h00;
    if (reg_wr && reg_addr == `RTM_OFS_STATUS)
    begin
      status_nxt[`RTM_BIT_HOST_EN] = reg_wdata[`RTM_BIT_HOST_EN];
      status_nxt[`RTM_BIT_CARD_EN] = reg_wdata[`RTM_BIT_CARD_EN];
    end
    // set beats clear when both land in one cycle
    status_nxt = (status_nxt & ~`RTM_FLAG_MASK)
               | rtm_w1c(status_r, (reg_wr && reg_addr == `RTM_OFS_STATUS) ? reg_wdata : 8'h00, ev_vec);
    if (reg_wr && reg_addr == `RTM_OFS_IRQ_STAT)
      istat_nxt = rtm_w1c(istat_r, reg_wdata, ev_vec);
    if (reg_wr && reg_addr == `RTM_OFS_IRQ_MASK)
      imask_nxt = reg_wdata & `RTM_FLAG_MASK;
    if (reg_rd)
    begin
      case (reg_addr)
        `RTM_OFS_STATUS:   rdata_nxt = status_r & (`RTM_FLAG_MASK | `RTM_EN_MASK);
        `RTM_OFS_IRQ_STAT: rdata_nxt = istat_r;
        `RTM_OFS_IRQ_MASK: rdata_nxt = imask_r;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      status_r <= `RTM_STATUS_RESET;
      istat_r  <= 8'h00;
      imask_r  <= 8'h00;
      rdata_r  <= 8'h00;
    end
    else
    begin
      status_r <= status_nxt;
      istat_r  <= istat_nxt;
      imask_r  <= imask_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign reg_rdata           = rdata_r;
  assign host_retry_count_en = status_r[`RTM_BIT_HOST_EN];
  assign card_retry_count_en = status_r[`RTM_BIT_CARD_EN];
  assign irq                 = |(istat_r & imask_r);
endmodule : rtm_reg_file

// ---- test/rtm_checker.sv ----
// port assertions of the retry timeout monitor
`timescale 1ns/10ps
module rtm_checker #(
  parameter int CNT_W = 15
)
(
  // clock, reset and register port
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // events and status
  input wire logic       host_retry,
  input wire logic       host_reissue,
  input wire logic       card_b_retry,
  input wire logic       card_b_reissue,
  input wire logic       host_retry_expired,
  input wire logic       card_a_retry_expired,
  input wire logic       card_b_retry_expired,
  input wire logic       irq
);
  localparam int LIM = (1 << CNT_W) + 2;
  localparam int EXP = 1 << CNT_W;
  wire logic st = reg_wr && reg_addr == 8'h90;
  // saturating age since last retry, forced to the limit by reissue; enable toggles are not seen here
  int age_r [2];
  always_ff @(posedge core_clk)
  begin
    age_r[0] <= (!resetn || host_retry || host_reissue) ? LIM : (age_r[0] < LIM ? age_r[0] + 1 : LIM);
    age_r[1] <= (!resetn || card_b_retry || card_b_reissue) ? LIM : (age_r[1] < LIM ? age_r[1] + 1 : LIM);
    if (resetn && host_retry)
      age_r[0] <= 0;
    if (resetn && card_b_retry)
      age_r[1] <= 0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_HOST_TIME: assert property ($rose(host_retry_expired) |-> age_r[0] inside {[EXP:EXP + 1]})
    else $error("host flag rose at wrong time");
  AST_CARDB_TIME: assert property ($rose(card_b_retry_expired) |-> age_r[1] inside {[EXP:EXP + 1]})
    else $error("card b flag rose at wrong time");
  AST_CLR_HOST: assert property (st && reg_wdata[1] && !(age_r[0] inside {[EXP - 2:EXP + 1]}) |=> !host_retry_expired)
    else $error("host flag not cleared");
  AST_KEEP_A: assert property (card_a_retry_expired && !(st && reg_wdata[3]) |=> card_a_retry_expired)
    else $error("card a flag lost");
  AST_RSVD: assert property (reg_rd && reg_addr == 8'h90 |=> (reg_rdata & 8'h15) == 8'h00)
    else $error("reserved bits not zero");
  AST_READ_FLAGS: assert property (reg_rd && reg_addr == 8'h90 |=>
    {reg_rdata[5], reg_rdata[3], reg_rdata[1]}
    == $past({card_b_retry_expired, card_a_retry_expired, host_retry_expired}))
    else $error("status read differs from flags");
  AST_IDLE_RD: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_RESET: assert property (disable iff (1'b0) !resetn |=> !host_retry_expired && !card_a_retry_expired
    && !card_b_retry_expired && !irq && reg_rdata == 8'h00)
    else $error("outputs not cleared by reset");
  cover property ($rose(card_b_retry_expired));
  cover property ($rose(irq));
  cover property (st && reg_wdata[1] && host_retry_expired);
endmodule : rtm_checker

bind rtm_retry_timeout_monitor rtm_checker #(.CNT_W(CNT_W)) chk_i (.*);

// ---- test/rtm_target_model.sv ----
// retrying targets: retry now, reissue after dly cycles or never when dly is zero
`timescale 1ns/10ps
module rtm_target_model
(
  // command from the bench
  input wire logic       core_clk,
  input wire logic       go,
  input wire logic [1:0] tsel,
  input wire logic [7:0] dly,
  // master-side events
  output logic     [2:0] retry,
  output logic     [2:0] reissue
);
  logic [7:0] cnt_r = 8'h00;
  logic [1:0] who_r = 2'h0;
  always_ff @(posedge core_clk)
  begin
    retry   <= go ? 3'h1 << tsel : 3'h0;
    reissue <= (cnt_r == 8'h01) ? 3'h1 << who_r : 3'h0;
    if (go)
    begin
      cnt_r <= dly;
      who_r <= tsel;
    end
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
  end
endmodule : rtm_target_model

// ---- test/test_retry_timeout_monitor.sv ----
// self-checking bench of the retry timeout monitor
`timescale 1ns/10ps
module test_retry_timeout_monitor;
  localparam int CW = 4;
  logic        core_clk  = 1'b0;
  logic        resetn    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        go        = 1'b0;
  logic [1:0]  tsel      = 2'h0;
  logic [7:0]  dly       = 8'h00;
  logic [31:0] seed      = 32'h0DA62F93;
  logic [7:0]  reg_rdata;
  logic [2:0]  rt;
  logic [2:0]  ri;
  logic [2:0]  fl;
  logic        irq;
  int          err_count = 0;
  int          n_checks  = 0;
  rtm_target_model pm (.core_clk, .go, .tsel, .dly, .retry(rt), .reissue(ri));
  rtm_retry_timeout_monitor #(.CNT_W(CW)) uut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .host_retry(rt[0]), .host_reissue(ri[0]), .card_a_retry(rt[1]), .card_a_reissue(ri[1]),
    .card_b_retry(rt[2]), .card_b_reissue(ri[2]), .host_retry_expired(fl[0]), .card_a_retry_expired(fl[1]),
    .card_b_retry_expired(fl[2]), .irq);
  initial
    forever #50 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] stat_exp(input logic [1:0] en, input logic [2:0] f);
    return {en, f[2], 1'b0, f[1], 1'b0, f[0], 1'b0};
  endfunction : stat_exp
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk("rdata", reg_rdata, exp);
    tick(1);
  endtask : rdc
  task automatic kick(input int t, input logic [7:0] d);
    go   <= 1'b1;
    tsel <= 2'(t);
    dly  <= d;
    tick(1);
    go <= 1'b0;
    tick(1);
  endtask : kick
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    tick(3000);
    err_count++;
    close_out();
  end
  initial
  begin
    tick(16);
    resetn <= 1'b1;
    tick(1);
    rdc(8'h90, 8'hC0);
    chk("flags", {5'h00, fl}, 8'h00);
    rdc(8'h5C, 8'h00);
    seed = lfsr(seed);
    wr(8'h90, (seed[7:0] & 8'hD5) | 8'hC0);
    rdc(8'h90, 8'hC0);
    wr(8'hA4, 8'h2A);
    for (int t = 0; t < 3; t++)
    begin
      seed = lfsr(seed);
      kick(t, 8'h01 + seed[7:0] % 8'h0E);
      tick(24);
      chk("early", {5'h00, fl}, 8'h00);
      kick(t, 8'h00);
      tick(2 ** CW + 4);
      rdc(8'h90, stat_exp(2'b11, 3'h1 << t));
      chk("irq", {7'h00, irq}, 8'h01);
      wr(8'h90, 8'hC0);
      chk("keep", {5'h00, fl}, 8'h01 << t);
      wr(8'h90, stat_exp(2'b11, 3'h1 << t));
      wr(8'hA0, 8'h2A);
      rdc(8'h90, 8'hC0);
      chk("irq", {7'h00, irq}, 8'h00);
    end
    wr(8'h90, 8'h00);
    for (int t = 0; t < 3; t++)
      kick(t, 8'h00);
    tick(2 ** CW + 4);
    rdc(8'h90, 8'h00);
    wr(8'hA4, 8'h00);
    wr(8'h90, 8'h80);
    kick(0, 8'h00);
    kick(2, 8'h00);
    tick(2 ** CW + 4);
    rdc(8'h90, 8'h82);
    chk("masked", {7'h00, irq}, 8'h00);
    wr(8'hA4, 8'h02);
    chk("unmasked", {7'h00, irq}, 8'h01);
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    tick(1);
    rdc(8'h90, 8'hC0);
    chk("irq", {4'h0, irq, fl}, 8'h00);
    close_out();
  end
endmodule : test_retry_timeout_monitor
